/* File: core/hcbp_defs.vh */
// Purpose: Constants of the clamp, preblank and blanking pulse generator
// Assumes: Included by bare name from core design files
// Notes:   Field codes are word indices inside one register group
`ifndef HCBP_DEFS_VH
`define HCBP_DEFS_VH

// Per-sequence register group, word index
`define HCBP_F_CTRL        5'h00
`define HCBP_F_CLP_T1      5'h01
`define HCBP_F_CLP_T2      5'h02
`define HCBP_F_PBK_T1      5'h03
`define HCBP_F_PBK_T2      5'h04
`define HCBP_F_EVEN0       5'h05
`define HCBP_F_ODD0        5'h0B
`define HCBP_F_LAST        5'h10

// Global register group, word index
`define HCBP_G_CLP_MASK0   5'h00
`define HCBP_G_PBK_MASK0   5'h06
`define HCBP_G_MASK_LAST   5'h0B
`define HCBP_G_STATUS      5'h0C

// Control word bit positions
`define HCBP_B_CLP_POL     0
`define HCBP_B_PBK_POL     1
`define HCBP_B_MODE        2
`define HCBP_B_LVL_P1      4
`define HCBP_B_LVL_P2      5
`define HCBP_B_LVL_LS      6

// Status word bit positions
`define HCBP_B_ST_LINE     0
`define HCBP_B_ST_BLANK    13
`define HCBP_B_ST_SEQ      16

// Blanking modes
`define HCBP_MODE_NORMAL   2'h0
`define HCBP_MODE_MIX      2'h1
`define HCBP_MODE_ADV      2'h2
`define HCBP_MODE_TEST     2'h3

// Reset values
`define HCBP_RST_WORD      13'h0000
`define HCBP_RST_MSTART    13'h1FFF
`define HCBP_RST_MEND      13'h0000

`endif

/* File: core/hcbp_gen.v */
// Purpose: Clamp, preblank and horizontal blanking pulses for a CCD line
// Assumes: line_start/field_start are one-cycle pulses synchronous to clk
// Notes:   Avalon-MM slave, one wait cycle per access
// What this block does
// R1: Clamp and preblank each restart every line at their own start polarity bit.
// R2: Clamp and preblank flip level at two 13-bit pixel toggle positions.
// R3: Software treats clamp and preblank as active low when programming them.
// R4: Each vertical sequence holds its own clamp and preblank pattern.
// R5: Clamp or preblank suppressed from programmed start line through end line.
// R6: Masking silences outputs but leaves every stored pattern untouched.
// R7: Three masking areas for clamp and three for preblank.
// R8: Masking areas are global, active in every field and sequence.
// R9: Software disables masking with all ones or a line beyond field length.
// R10: At power-up software sets mask start 8191 and mask end 0.
// R11: Blanking has no start polarity; only toggles place each interval.
// R12: Separate blanking levels for phase-one, phase-two and last-stage clocks.
// R13: Phase-one level bit high drives phase-one clocks low while blanking.
// R14: Each vertical sequence holds its own blanking settings.
// R15: Three blanking modes: basic, pixel mixing and advanced; mode 1 (mixing) runs the same six toggles as basic here.
// R16: Basic mode offers six blanking toggle positions per line.
// R17: Software normally uses only two blanking toggles for a plain interval.
// R18: Even and odd lines use separate toggle sets; equal sets for no alternation.
// R19: Two-bit mode: 0 normal, 1 mixing, 2 advanced, 3 reserved.
// R20: Blanking toggles are 13-bit pixel positions, separate for odd and even.
// R21: Toggles match the pixel counter, mask lines the line counter.
`include "hcbp_defs.vh"
`timescale 1ns/10ps
`default_nettype none

module hcbp_gen #(
  parameter SEQ_BITS = 2
) (
  // Clock, reset, enable
  input  wire                  clk,
  input  wire                  reset_n,
  input  wire                  clk_en,
  // Line and field timing
  input  wire                  line_start,
  input  wire                  field_start,
  input  wire [SEQ_BITS-1:0]   vseq_sel,
  // Raw horizontal clocks from the edge generator
  input  wire                  hclk_phase_one_raw,
  input  wire                  hclk_phase_two_raw,
  input  wire                  hclk_last_stage_raw,
  // Avalon-MM slave
  input  wire [SEQ_BITS+7:0]   avs_address,
  input  wire                  avs_read,
  input  wire                  avs_write,
  input  wire [31:0]           avs_writedata,
  input  wire [3:0]            avs_byteenable,
  output reg  [31:0]           avs_readdata,
  output reg                   avs_waitrequest,
  // Sensor and front-end pulses
  output reg                   optical_black_clamp_pulse,
  output reg                   preblank_pulse,
  output reg                   horizontal_blank_pulse,
  output reg                   hclk_phase_one,
  output reg                   hclk_phase_two,
  output reg                   hclk_last_stage
);

  localparam SEQ_DEPTH = 1 << (SEQ_BITS + 5);
  localparam W_HI      = SEQ_BITS + 7;

  // Reset release
  reg                  rst_meta_q;
  reg                  rst_n_q;

  // Counters and running pattern state
  reg  [12:0]          pix_q;
  reg  [12:0]          line_q;
  reg  [SEQ_BITS-1:0]  seq_q;
  reg                  clp_lvl_q;
  reg                  pbk_lvl_q;
  reg                  blank_q;

  // Register storage
  reg  [12:0]          seq_mem  [0:SEQ_DEPTH-1];
  reg  [12:0]          mask_mem [0:11];

  // Next values
  reg  [12:0]          pix_d;
  reg  [12:0]          line_d;
  reg  [SEQ_BITS-1:0]  seq_now;
  reg                  clp_lvl_d;
  reg                  pbk_lvl_d;
  reg                  blank_d;
  reg  [31:0]          rdata_d;

  wire [5:0]           tog_hit;
  wire [2:0]           clp_mhit;
  wire [2:0]           pbk_mhit;

  // Bus decode
  wire [W_HI-2:0]      word    = avs_address[W_HI:2];
  wire                 glb     = avs_address[W_HI];
  wire [4:0]           fld     = word[4:0];
  wire [SEQ_BITS+4:0]  seq_idx = word[SEQ_BITS+4:0];
  wire                 seq_ok  = ~glb && (fld <= `HCBP_F_LAST);
  wire                 mask_ok = glb && (fld <= `HCBP_G_MASK_LAST);
  wire [3:0]           mask_ix = fld[3:0];
  wire [12:0]          cur_val = glb ? mask_mem[mask_ix] : seq_mem[seq_idx];
  wire [12:0]          wr_val  = {avs_byteenable[1] ? avs_writedata[12:8] : cur_val[12:8],
                                  avs_byteenable[0] ? avs_writedata[7:0]  : cur_val[7:0]};
  wire                 wr_go   = avs_write && !avs_waitrequest;

  // Active sequence settings
  wire [12:0]          ctrl_w  = seq_mem[{seq_now, `HCBP_F_CTRL}];
  wire [12:0]          clp_t1  = seq_mem[{seq_now, `HCBP_F_CLP_T1}];
  wire [12:0]          clp_t2  = seq_mem[{seq_now, `HCBP_F_CLP_T2}];
  wire [12:0]          pbk_t1  = seq_mem[{seq_now, `HCBP_F_PBK_T1}];
  wire [12:0]          pbk_t2  = seq_mem[{seq_now, `HCBP_F_PBK_T2}];
  wire [1:0]           mode    = ctrl_w[`HCBP_B_MODE +: 2];

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  always @* begin
    // A new line picks up the sequence presented with its start pulse
    seq_now = line_start ? vseq_sel : seq_q; // R4 R14
    pix_d   = line_start ? 13'h0000 : pix_q + 13'h0001; // R21
    if (field_start) begin
      line_d = 13'h0000; // R21
    end else if (line_start) begin
      line_d = line_q + 13'h0001;
    end else begin
      line_d = line_q;
    end
  end

  // Blanking toggles, odd set on odd lines
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_tog
      localparam [4:0] F_EVEN = `HCBP_F_EVEN0 + g;
      localparam [4:0] F_ODD  = `HCBP_F_ODD0 + g;
      wire [12:0] pos = line_d[0] ? seq_mem[{seq_now, F_ODD}]
                                  : seq_mem[{seq_now, F_EVEN}]; // R18 R20
      // Advanced mode keeps only the plain interval pair
      assign tog_hit[g] = (pos == pix_d) &&
                          ((mode != `HCBP_MODE_ADV) || (g < 2)); // R15 R16
    end
    for (g = 0; g < 3; g = g + 1) begin : g_mask
      assign clp_mhit[g] = (line_d >= mask_mem[`HCBP_G_CLP_MASK0 + 2 * g]) &&
                           (line_d <= mask_mem[`HCBP_G_CLP_MASK0 + 2 * g + 1]); // R5 R7 R8
      assign pbk_mhit[g] = (line_d >= mask_mem[`HCBP_G_PBK_MASK0 + 2 * g]) &&
                           (line_d <= mask_mem[`HCBP_G_PBK_MASK0 + 2 * g + 1]); // R5 R7 R8
    end
  endgenerate

  always @* begin
    clp_lvl_d = line_start ? ctrl_w[`HCBP_B_CLP_POL] : clp_lvl_q; // R1
    clp_lvl_d = clp_lvl_d ^ (pix_d == clp_t1) ^ (pix_d == clp_t2); // R2
    pbk_lvl_d = line_start ? ctrl_w[`HCBP_B_PBK_POL] : pbk_lvl_q; // R1
    pbk_lvl_d = pbk_lvl_d ^ (pix_d == pbk_t1) ^ (pix_d == pbk_t2); // R2
    // Every line starts outside the blanking interval unless a toggle sits at pixel 0
    blank_d = (line_start ? 1'b0 : blank_q) ^ (^tog_hit); // R11
    // Reserved test mode keeps blanking off
    if (mode == `HCBP_MODE_TEST) begin
      blank_d = 1'b0; // R19
    end
  end

  always @* begin
    rdata_d = 32'h0000_0000;
    if (seq_ok || mask_ok) begin
      rdata_d[12:0] = cur_val;
    end else if (glb && (fld == `HCBP_G_STATUS)) begin
      rdata_d[`HCBP_B_ST_LINE +: 13]      = line_q;
      rdata_d[`HCBP_B_ST_BLANK]           = blank_q;
      rdata_d[`HCBP_B_ST_SEQ +: SEQ_BITS] = seq_q;
    end
  end

  // Bus slave and register storage
  integer i;
  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
      for (i = 0; i < SEQ_DEPTH; i = i + 1) begin
        seq_mem[i] <= `HCBP_RST_WORD;
      end
      // Areas come up disabled: start past end
      for (i = 0; i < 12; i = i + 2) begin
        mask_mem[i]     <= `HCBP_RST_MSTART;
        mask_mem[i + 1] <= `HCBP_RST_MEND;
      end
    end else if (clk_en) begin
      if ((avs_read || avs_write) && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        avs_readdata    <= rdata_d;
      end else begin
        avs_waitrequest <= 1'b1;
      end
      // Writes only store; masking never touches the pattern words
      if (wr_go && seq_ok) begin
        seq_mem[seq_idx] <= wr_val; // R6
      end
      if (wr_go && mask_ok) begin
        mask_mem[mask_ix] <= wr_val;
      end
    end
  end

  // Pulse generation
  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pix_q                     <= 13'h0000;
      line_q                    <= 13'h0000;
      seq_q                     <= {SEQ_BITS{1'b0}};
      clp_lvl_q                 <= 1'b1;
      pbk_lvl_q                 <= 1'b1;
      blank_q                   <= 1'b0;
      optical_black_clamp_pulse <= 1'b1;
      preblank_pulse            <= 1'b1;
      horizontal_blank_pulse    <= 1'b0;
      hclk_phase_one            <= 1'b0;
      hclk_phase_two            <= 1'b0;
      hclk_last_stage           <= 1'b0;
    end else if (clk_en) begin
      pix_q     <= pix_d;
      line_q    <= line_d;
      seq_q     <= seq_now;
      clp_lvl_q <= clp_lvl_d;
      pbk_lvl_q <= pbk_lvl_d;
      blank_q   <= blank_d;
      // Masked lines show the inactive high level
      optical_black_clamp_pulse <= (|clp_mhit) | clp_lvl_d; // R5 R6
      preblank_pulse            <= (|pbk_mhit) | pbk_lvl_d; // R5 R6
      horizontal_blank_pulse    <= blank_d;
      // Level bit set means the clock group sits low while blanking
      hclk_phase_one  <= blank_d ? ~ctrl_w[`HCBP_B_LVL_P1] : hclk_phase_one_raw; // R12 R13
      hclk_phase_two  <= blank_d ? ~ctrl_w[`HCBP_B_LVL_P2] : hclk_phase_two_raw; // R12
      hclk_last_stage <= blank_d ? ~ctrl_w[`HCBP_B_LVL_LS] : hclk_last_stage_raw; // R12
    end
  end

endmodule

`default_nettype wire

/* File: tb/hcbp_gen_sva.sv */
// Purpose: Handshake and H-clock checks on hcbp_gen ports
// Assumes: Bound to every hcbp_gen instance
// Notes:   Pulse levels are checked by the bench
`timescale 1ns/10ps
`default_nettype none
module hcbp_gen_sva #(
  parameter SEQ_BITS = 2
) (
  // Clock and control
  input wire logic                clk,
  input wire logic                reset_n,
  input wire logic                clk_en,
  input wire logic                line_start,
  // Bus
  input wire logic                avs_read,
  input wire logic                avs_write,
  input wire logic [SEQ_BITS+7:0] avs_address,
  input wire logic [31:0]         avs_readdata,
  input wire logic                avs_waitrequest,
  // Blanking and H clocks
  input wire logic                horizontal_blank_pulse,
  input wire logic                hclk_phase_one_raw,
  input wire logic                hclk_phase_two_raw,
  input wire logic                hclk_last_stage_raw,
  input wire logic                hclk_phase_one,
  input wire logic                hclk_phase_two,
  input wire logic                hclk_last_stage
);
  logic [3:0] live_q;
  // Internal reset lags the pin by two edges
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      live_q <= 4'h0;
    else
      live_q <= {live_q[2:0], 1'b1};
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wait_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest && clk_en
    |=> !avs_waitrequest) else $error("bus answer late");
  wait_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer longer than one cycle");
  wait_cause_a: assert property (!avs_waitrequest |-> $past(avs_read) || $past(avs_write))
    else $error("answer without request");
  wait_idle_a: assert property (!avs_read && !avs_write && avs_waitrequest
    |=> avs_waitrequest) else $error("answer while idle");
  read_width_a: assert property (
    !avs_waitrequest && avs_read && !avs_address[SEQ_BITS+7] |-> avs_readdata[31:13] == 19'h0)
    else $error("wide readdata");
  hclk_follow_a: assert property (live_q[3] && $past(clk_en) && !horizontal_blank_pulse
    |-> hclk_phase_one == $past(hclk_phase_one_raw) && hclk_phase_two == $past(hclk_phase_two_raw)
    && hclk_last_stage == $past(hclk_last_stage_raw)) else $error("h clock not passed");
  blank_hold_a: assert property (
    live_q[3] && horizontal_blank_pulse && $past(horizontal_blank_pulse) && !$past(line_start)
    |-> $stable(hclk_phase_one)
    && $stable(hclk_phase_two) && $stable(hclk_last_stage)) else $error("h clock moved in blank");
  stall_freeze_a: assert property (live_q[3] && !clk_en
    |=> $stable(hclk_phase_one) && $stable(avs_waitrequest)) else $error("stall not frozen");
endmodule
bind hcbp_gen hcbp_gen_sva #(.SEQ_BITS(SEQ_BITS)) u_sva (.clk(clk), .reset_n(reset_n),
  .clk_en(clk_en), .line_start(line_start), .avs_read(avs_read), .avs_write(avs_write),
  .avs_address(avs_address),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .horizontal_blank_pulse(horizontal_blank_pulse), .hclk_phase_one_raw(hclk_phase_one_raw),
  .hclk_phase_two_raw(hclk_phase_two_raw), .hclk_last_stage_raw(hclk_last_stage_raw),
  .hclk_phase_one(hclk_phase_one), .hclk_phase_two(hclk_phase_two),
  .hclk_last_stage(hclk_last_stage));
`default_nettype wire

/* File: tb/hcbp_afe_model.sv */
// Purpose: Raw H-clock source at the far side
// Assumes: One pixel clock
// Notes:   Last stage runs at half rate so a swapped group shows
`timescale 1ns/10ps
`default_nettype none
module hcbp_afe_model (
  // Clock
  input  wire logic clk,
  // Raw H clocks
  output wire logic hclk_phase_one_raw,
  output wire logic hclk_phase_two_raw,
  output wire logic hclk_last_stage_raw
);
  logic [1:0] ph_q = 2'h0;
  always @(posedge clk) ph_q <= ph_q + 2'h1;
  assign hclk_phase_one_raw  = ph_q[0];
  assign hclk_phase_two_raw  = ~ph_q[0];
  assign hclk_last_stage_raw = ph_q[1];
endmodule
`default_nettype wire

/* File: tb/hcbp_gen_tb_top.sv */
// Purpose: Self-checking bench for hcbp_gen
// Assumes: 24-pixel lines; sequence s runs blank mode s
// Notes:   Drivers note expectations in queues; watchers pop them
`timescale 1ns/10ps
`default_nettype none
module hcbp_gen_tb_top;
  logic        clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, on_q = 1'b0;
  logic        line_start = 1'b0, field_start = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [1:0]  vseq_sel = 2'h0;
  logic [9:0]  avs_address = 10'h000;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, v;
  logic        avs_waitrequest, clamp, preblank, blank, h1r, h2r, hlr, h1o, h2o, hlo;
  logic [5:0]  e;
  logic [12:0] tg[4][17];
  logic [12:0] msk[12];
  logic [31:0] rq[$];
  logic [5:0]  pq[$];
  int          mismatches = 0, total_checks = 0, s, f;
  always #4 clk = ~clk;
  hcbp_afe_model afe (.clk(clk), .hclk_phase_one_raw(h1r), .hclk_phase_two_raw(h2r),
    .hclk_last_stage_raw(hlr));
  hcbp_gen #(.SEQ_BITS(2)) uut (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
    .line_start(line_start), .field_start(field_start), .vseq_sel(vseq_sel),
    .hclk_phase_one_raw(h1r), .hclk_phase_two_raw(h2r), .hclk_last_stage_raw(hlr),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .optical_black_clamp_pulse(clamp),
    .preblank_pulse(preblank), .horizontal_blank_pulse(blank), .hclk_phase_one(h1o),
    .hclk_phase_two(h2o), .hclk_last_stage(hlo));
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Entered right after an edge; leaves one idle cycle between accesses
  task automatic acc(input logic w, input logic [9:0] a, input logic [31:0] d);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    rq.push_back(e);
    acc(1'b0, a, 32'h0);
  endtask
  task automatic line(input int ln);
    int q, p, a;
    logic c, k, b;
    q = (ln >> 1) % 4;
    for (p = 0; p < 24; p++) begin
      c = tg[q][0][0] ^ (tg[q][1] <= p) ^ (tg[q][2] <= p);
      k = tg[q][0][1] ^ (tg[q][3] <= p) ^ (tg[q][4] <= p);
      b = 1'b0;
      for (a = 0; a < 6; a++)
        b = b ^ ((tg[q][5 + 6 * (ln % 2) + a] <= p) && (a < 2 || q < 2));
      for (a = 0; a < 3; a++) begin
        c = c | (msk[2 * a] <= ln && ln <= msk[2 * a + 1]);
        k = k | (msk[6 + 2 * a] <= ln && ln <= msk[7 + 2 * a]);
      end
      pq.push_back({c, k, b & (q != 3), ~tg[q][0][4], ~tg[q][0][5], ~tg[q][0][6]});
    end
    vseq_sel <= q[1:0];
    line_start <= 1'b1;
    field_start <= (ln == 0);
    @(posedge clk);
    line_start <= 1'b0;
    field_start <= 1'b0;
    repeat (23) @(posedge clk);
  endtask
  always @(posedge clk) begin
    if (avs_read && avs_waitrequest === 1'b0)
      cmp(avs_readdata, rq.pop_front());
    if (on_q && pq.size() > 0) begin
      e = pq.pop_front();
      cmp({29'h0, clamp, preblank, blank}, {29'h0, e[5:3]});
      if (e[3])
        cmp({29'h0, h1o, h2o, hlo}, {29'h0, e[2:0]});
    end
    if (line_start)
      on_q <= 1'b1;
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    $display("wrong value at %0t: run timed out", $time);
    finish_test;
  end
  initial begin
    v = $urandom(32'h8077);
    msk = '{1, 1, 3, 3, 9, 8, 2, 2, 8191, 0, 5, 6};
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(10'h200, 32'h1FFF);
    rd(10'h22C, 32'h0);
    rd(10'h180, 32'h0);
    acc(1'b1, 10'h234, 32'h1234);
    rd(10'h234, 32'h0);
    for (f = 1; f < 3; f++) begin
      v = $urandom;
      acc(1'b1, 10'(384 + 4 * f), v);
      rd(10'(384 + 4 * f), {19'h0, v[12:0]});
    end
    $display("test registers done");
    clk_en <= 1'b0;
    repeat (4) @(posedge clk);
    clk_en <= 1'b1;
    @(posedge clk);
    // Level bits first: changing them later could move H clocks mid-blank
    for (s = 0; s < 4; s++) begin
      tg[s][0] = 13'(($urandom % 8) * 16 + s * 4 + $urandom % 4);
      acc(1'b1, 10'(s * 128), {19'h0, tg[s][0]});
    end
    for (s = 0; s < 4; s++)
      for (f = 1; f < 17; f++) begin
        tg[s][f] = 13'($urandom % 24);
        acc(1'b1, 10'(s * 128 + 4 * f), {19'h0, tg[s][f]});
      end
    for (f = 0; f < 12; f++)
      acc(1'b1, 10'(512 + 4 * f), {19'h0, msk[f]});
    for (f = 0; f < 10; f++)
      line(f % 8);
    repeat (3) @(posedge clk);
    rd(10'h004, {19'h0, tg[0][1]});
    $display("test pulses done");
    finish_test;
  end
endmodule
`default_nettype wire
